// File: hw/rws_pkg.sv
// constants and carrier types for the reset and watchdog supervisor
package rws_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int RESET_FILTER_US = 10;
  localparam int RESET_FILTER_TICKS = (RESET_FILTER_US + TICK_US - 1) / TICK_US;
  localparam int RESET_DELAY_US = 10000;
  localparam int RESET_DELAY_TICKS = (RESET_DELAY_US + TICK_US - 1) / TICK_US;
  localparam int LONG_OPEN_WINDOW_MS = 200;
  localparam int LONG_OPEN_WINDOW_TICKS = LONG_OPEN_WINDOW_MS * 1000 / TICK_US;
  localparam int CLOSED_PCT = 60;
  localparam int TICK_W = 16;

  // ************************************************************
  // watchdog control word layout
  // ************************************************************
  localparam int WDC_CHK_BIT = 7;
  localparam int WDC_WIN_BIT = 4;
  localparam int WDC_STOPOFF_BIT = 3;
  localparam int WDC_PER_LSB = 0;
  localparam logic [7:0] WDC_RESET = 8'h05;
  localparam logic [2:0] PERIOD_RESET = 3'h5;

  // ************************************************************
  // modes
  // ************************************************************
  typedef enum logic [2:0] {
    RWS_INIT = 3'b000,
    RWS_NORMAL = 3'b001,
    RWS_STOP = 3'b010,
    RWS_SLEEP = 3'b011,
    RWS_RESTART = 3'b100,
    RWS_FAILSAFE = 3'b101
  } rws_mode_t;

  localparam logic [1:0] MODE_CMD_SOFT_RESET = 2'h3;
  localparam logic [1:0] THRESH_DEFAULT = 2'h0;

  typedef struct packed {
    logic window_select;
    logic stop_off;
    logic [2:0] period;
  } rws_wdog_cfg_t;

  typedef struct packed {
    logic reset_clamp_flag;
    logic core_supply_undervolt_flag;
    logic wdog_failure_flag;
    logic serial_fail_flag;
  } rws_status_t;
endpackage

// File: hw/rws_tick_div.sv
// divider making the oscillator tick enable
`timescale 1ns/100ps
module rws_tick_div #(
  parameter int DIV = rws_pkg::TICK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  output logic o_tick
);
  initial begin
    if (DIV < 1 || DIV > 65535) begin
      $error("divider out of range");
    end
  end

  logic [15:0] cnt_q;

  // one-cycle tick every DIV clocks
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign o_tick = (cnt_q == 16'(DIV - 1));
endmodule

// File: hw/rws_supervisor.sv
// reset output and watchdog supervisor core
`timescale 1ns/100ps
module rws_supervisor #(
  parameter int TICK_CYC = rws_pkg::TICK_CYC,
  parameter int LONG_WIN_TICKS = rws_pkg::LONG_OPEN_WINDOW_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_core_supply_uv,
  input wire logic i_core_supply_ge_1v,
  input wire logic i_battery_supply_ok,
  input wire logic i_reset_pin_fb,
  input wire logic [1:0] i_thresh_sel,
  input wire logic i_thresh_wr,
  input wire logic [1:0] i_mode_cmd,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_wdog_wdata,
  input wire logic i_wdog_wr,
  input wire logic i_chip_select_n,
  input wire logic i_status_clr,
  output logic o_reset_out_n,
  output logic o_reset_out_oe_n,
  output logic [1:0] o_thresh_sel,
  output rws_pkg::rws_mode_t o_mode,
  output rws_pkg::rws_wdog_cfg_t o_wdog_cfg,
  output rws_pkg::rws_status_t o_status
);
  initial begin
    if (LONG_WIN_TICKS < 1 || LONG_WIN_TICKS > 65535) begin
      $error("long window out of range");
    end
  end

  // ************************************************************
  // tick and period decode
  // ************************************************************
  logic tick;
  rws_tick_div #(.DIV(TICK_CYC)) u_div (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .o_tick(tick)
  );

  localparam logic [15:0] RFT = 16'(rws_pkg::RESET_FILTER_TICKS);
  localparam logic [15:0] RDT = 16'(rws_pkg::RESET_DELAY_TICKS);
  localparam int MS_T = 1000 / rws_pkg::TICK_US;

  // period in ticks per setting; 0 maps like setting 1
  function automatic logic [15:0] period_ticks(input logic [2:0] s);
    int ms;
    unique case (s)
      3'h2: ms = 20;
      3'h3: ms = 50;
      3'h4: ms = 100;
      3'h5: ms = 200;
      3'h6: ms = 500;
      3'h7: ms = 1000;
      default: ms = 10;
    endcase
    return 16'(ms * MS_T);
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  rws_pkg::rws_mode_t mode_q;
  rws_pkg::rws_wdog_cfg_t cfg_q;
  rws_pkg::rws_status_t stat_q;
  logic [1:0] thr_q;
  logic rst_low_q;
  logic uv_cause_q;
  logic [15:0] flt_q;
  logic [15:0] dly_q;
  logic [15:0] wdt_q;
  logic wd_on_q;
  logic long_q;
  logic cs_q;
  logic trig_pend_q;
  logic [7:0] trig_data_q;
  logic wdog_failure_flags_evt;
  logic [15:0] per;

  assign per = period_ticks(cfg_q.period);

  // ************************************************************
  // host write decode
  // ************************************************************
  logic parity_ok;
  logic soft_rst;
  logic cs_rise;
  logic cfg_wr_ok;
  assign parity_ok = ~(^i_wdog_wdata);
  assign cs_rise = i_chip_select_n && !cs_q;
  assign soft_rst = i_mode_wr && i_mode_cmd == rws_pkg::MODE_CMD_SOFT_RESET
    && (mode_q == rws_pkg::RWS_NORMAL || mode_q == rws_pkg::RWS_STOP);
  assign cfg_wr_ok = trig_pend_q && cs_rise && mode_q == rws_pkg::RWS_NORMAL;

  // chip select edge history
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cs_q <= 1'b1;
    end else begin
      cs_q <= i_chip_select_n;
    end
  end

  // latch a good watchdog write until chip select returns high
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      trig_pend_q <= 1'b0;
      trig_data_q <= rws_pkg::WDC_RESET;
    end else if (i_wdog_wr && parity_ok) begin
      trig_pend_q <= 1'b1;
      trig_data_q <= i_wdog_wdata;
    end else if (cs_rise) begin
      trig_pend_q <= 1'b0;
    end
  end

  // watchdog configuration, frozen outside Normal
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      cfg_q.window_select <= 1'b0;
      cfg_q.stop_off <= 1'b0;
      cfg_q.period <= rws_pkg::PERIOD_RESET;
    end else if (cfg_wr_ok) begin
      cfg_q.window_select <= trig_data_q[rws_pkg::WDC_WIN_BIT];
      cfg_q.stop_off <= trig_data_q[rws_pkg::WDC_STOPOFF_BIT];
      cfg_q.period <= trig_data_q[rws_pkg::WDC_PER_LSB +: 3];
    end
  end

  // threshold select, default after power-up and soft reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      thr_q <= rws_pkg::THRESH_DEFAULT;
    end else if (i_thresh_wr) begin
      thr_q <= i_thresh_sel;
    end
  end

  // ************************************************************
  // reset output sequencing
  // ************************************************************
  // undervoltage filter then delay after recovery
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rst_low_q <= 1'b1;
      uv_cause_q <= 1'b1;
      flt_q <= 16'h0000;
      dly_q <= RDT;
    end else if (wdog_failure_flags_evt) begin
      rst_low_q <= 1'b1;
      uv_cause_q <= 1'b0;
      dly_q <= RDT;
    end else if (i_core_supply_uv) begin
      dly_q <= RDT;
      if (rst_low_q) begin
        uv_cause_q <= 1'b1;
      end else if (tick) begin
        if (flt_q >= RFT - 16'h0001) begin
          rst_low_q <= 1'b1;
          uv_cause_q <= 1'b1;
          flt_q <= 16'h0000;
        end else begin
          flt_q <= flt_q + 16'h0001;
        end
      end
    end else begin
      flt_q <= 16'h0000;
      if (rst_low_q && tick) begin
        if (dly_q <= 16'h0001) begin
          rst_low_q <= 1'b0;
        end else begin
          dly_q <= dly_q - 16'h0001;
        end
      end
    end
  end

  // pin drives low only with adequate supplies; oe low while driving
  logic drive_low;
  assign drive_low = rst_low_q && i_core_supply_ge_1v && i_battery_supply_ok;
  assign o_reset_out_oe_n = ~drive_low;
  assign o_reset_out_n = 1'b0;

  // ************************************************************
  // mode sequencing
  // ************************************************************
  // soft reset goes to Init without touching the reset output
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mode_q <= rws_pkg::RWS_INIT;
    end else if (soft_rst) begin
      mode_q <= rws_pkg::RWS_INIT;
    end else if (wdog_failure_flags_evt || (rst_low_q && mode_q != rws_pkg::RWS_INIT)) begin
      mode_q <= rws_pkg::RWS_RESTART;
    end else if (!rst_low_q && mode_q == rws_pkg::RWS_RESTART) begin
      mode_q <= rws_pkg::RWS_NORMAL;
    end else if (i_mode_wr && !rst_low_q) begin
      unique case (i_mode_cmd)
        2'h0: mode_q <= rws_pkg::RWS_NORMAL;
        2'h1: mode_q <= rws_pkg::RWS_SLEEP;
        2'h2: mode_q <= rws_pkg::RWS_STOP;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // ************************************************************
  // watchdog timer
  // ************************************************************
  logic wd_run;
  logic trig_now;
  logic in_closed;
  logic [15:0] closed_end;
  assign closed_end = 16'((32'(per) * rws_pkg::CLOSED_PCT) / 100);
  assign wd_run = (mode_q == rws_pkg::RWS_INIT || mode_q == rws_pkg::RWS_NORMAL
    || (mode_q == rws_pkg::RWS_STOP && !cfg_q.stop_off)) && !rst_low_q;
  assign trig_now = trig_pend_q && cs_rise && wd_run;
  assign in_closed = cfg_q.window_select && !long_q && wdt_q < closed_end;
  assign wdog_failure_flags_evt = wd_on_q && wd_run && ((trig_now && in_closed)
    || (tick && wdt_q >= (long_q ? 16'(LONG_WIN_TICKS) : per) - 16'h0001));

  // elapsed count; long open window after each release
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst || !wd_run) begin
      wd_on_q <= 1'b0;
      long_q <= 1'b1;
      wdt_q <= 16'h0000;
    end else if (!wd_on_q) begin
      wd_on_q <= 1'b1;
      long_q <= 1'b1;
      wdt_q <= 16'h0000;
    end else if (trig_now) begin
      long_q <= 1'b0;
      wdt_q <= 16'h0000;
    end else if (tick) begin
      wdt_q <= wdt_q + 16'h0001;
    end
  end

  // ************************************************************
  // status flags, set wins over clear
  // ************************************************************
  logic clamp_evt;
  assign clamp_evt = rst_low_q && i_reset_pin_fb
    && (mode_q == rws_pkg::RWS_NORMAL || mode_q == rws_pkg::RWS_STOP
    || mode_q == rws_pkg::RWS_RESTART)
    && !i_core_supply_uv && !stat_q.core_supply_undervolt_flag;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      stat_q <= '0;
    end else begin
      stat_q.reset_clamp_flag <= clamp_evt
        || (stat_q.reset_clamp_flag && !i_status_clr);
      stat_q.core_supply_undervolt_flag <= i_core_supply_uv
        || (stat_q.core_supply_undervolt_flag && !i_status_clr);
      stat_q.wdog_failure_flag <= wdog_failure_flags_evt
        || (stat_q.wdog_failure_flag && !(i_status_clr || (trig_now && !in_closed)));
      stat_q.serial_fail_flag <= (i_wdog_wr && !parity_ok)
        || (stat_q.serial_fail_flag && !i_status_clr);
    end
  end

  assign o_thresh_sel = thr_q;
  assign o_mode = mode_q;
  assign o_wdog_cfg = cfg_q;
  assign o_status = stat_q;

  // ************************************************************
  // checks
  // ************************************************************
  soft_init_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    soft_rst |=> mode_q == rws_pkg::RWS_INIT && cfg_q.period == rws_pkg::PERIOD_RESET)
    else $error("soft reset did not restore init");
  soft_norst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    soft_rst && !rst_low_q |=> !rst_low_q)
    else $error("soft reset asserted reset output");
  soft_ignore_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_mode_wr && i_mode_cmd == rws_pkg::MODE_CMD_SOFT_RESET
    && mode_q == rws_pkg::RWS_SLEEP |=> mode_q != rws_pkg::RWS_INIT)
    else $error("soft reset accepted outside normal or stop");
  cfg_frozen_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    mode_q != rws_pkg::RWS_NORMAL && !soft_rst |=> $stable(cfg_q))
    else $error("config changed outside normal");
  wdog_failure_flags_rst_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wdog_failure_flags_evt |=> rst_low_q && mode_q == rws_pkg::RWS_RESTART && stat_q.wdog_failure_flag)
    else $error("watchdog failure not handled");
  drive_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !o_reset_out_oe_n |-> i_core_supply_ge_1v && i_battery_supply_ok && rst_low_q)
    else $error("reset driven with low supplies");
  // the converse: with supplies present an asserted reset must reach the pin
  drive_on_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    rst_low_q && i_core_supply_ge_1v && i_battery_supply_ok |-> !o_reset_out_oe_n)
    else $error("reset not driven with good supplies");
  parity_bad_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_wdog_wr && (^i_wdog_wdata) && !soft_rst |=> stat_q.serial_fail_flag)
    else $error("parity failure not flagged");
  clamp_mode_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(stat_q.reset_clamp_flag) |-> $past(mode_q) != rws_pkg::RWS_SLEEP
    && $past(mode_q) != rws_pkg::RWS_FAILSAFE)
    else $error("clamp flagged in sleep or fail-safe");
  // a low supply would make the pin read high anyway, so never judge then
  clamp_uv_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $rose(stat_q.reset_clamp_flag) |-> !$past(stat_q.core_supply_undervolt_flag)
    && !$past(i_core_supply_uv))
    else $error("clamp flagged during undervoltage");
  wd_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    mode_q == rws_pkg::RWS_RESTART ##1 mode_q == rws_pkg::RWS_RESTART |-> !wd_on_q)
    else $error("watchdog running in restart");
  // a good trigger on a running timer starts a fresh short period
  trig_restart_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    trig_now && wd_on_q && !in_closed && !soft_rst |=> wdt_q == 16'h0000 && !long_q)
    else $error("trigger did not restart watchdog");

  trig_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) trig_now && !long_q);
  wdfail_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) wdog_failure_flags_evt);
  clamp_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) clamp_evt);
  softrst_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) soft_rst);
endmodule

// File: verif/rws_host_model.sv
// host side model framing watchdog control bytes
`timescale 1ns/100ps
module rws_host_model (
  input wire logic i_ref_clk,
  output logic o_chip_select_n,
  output logic o_wdog_wr,
  output logic [7:0] o_wdog_wdata
);
  // idle: deselected, no strobe
  initial begin
    o_chip_select_n = 1'b1;
    o_wdog_wr = 1'b0;
    o_wdog_wdata = 8'h00;
  end
  // ********************
  // one byte per frame
  // ********************
  // bad flips the checksum on purpose
  task automatic send(input logic [6:0] body, input logic bad);
    @(posedge i_ref_clk);
    #1;
    o_chip_select_n = 1'b0;
    o_wdog_wr = 1'b1;
    o_wdog_wdata = {^body ^ bad, body};
    @(posedge i_ref_clk);
    #1;
    o_chip_select_n = 1'b1; // trigger acts on release
    o_wdog_wr = 1'b0;
    o_wdog_wdata = ~o_wdog_wdata; // released data must not look held
    @(posedge i_ref_clk);
    #1;
  endtask
endmodule

// File: verif/testbench.sv
// self-checking bench for the reset and watchdog supervisor
`timescale 1ns/100ps
module testbench;
  logic i_ref_clk, i_reset, uv, ge_1v, bat_ok, clamp_hi;
  logic thr_wr, mode_wr, st_clr, cs_n, wd_wr, rst_n, oe_n;
  logic [1:0] thr_sel, mode_cmd, thr_q;
  logic [7:0] wd_data;
  rws_pkg::rws_mode_t mode;
  rws_pkg::rws_wdog_cfg_t cfg;
  rws_pkg::rws_status_t st;
  int error_cnt = 0;
  int total_checks = 0;
  wire pin_fb = clamp_hi | oe_n; // pull-up unless driven low

  // short tick keeps the run small: 10 clocks, long window 5 ticks
  rws_supervisor #(.TICK_CYC(10), .LONG_WIN_TICKS(5)) u_dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_core_supply_uv(uv),
    .i_core_supply_ge_1v(ge_1v), .i_battery_supply_ok(bat_ok),
    .i_reset_pin_fb(pin_fb), .i_thresh_sel(thr_sel), .i_thresh_wr(thr_wr),
    .i_mode_cmd(mode_cmd), .i_mode_wr(mode_wr), .i_wdog_wdata(wd_data),
    .i_wdog_wr(wd_wr), .i_chip_select_n(cs_n), .i_status_clr(st_clr),
    .o_reset_out_n(rst_n), .o_reset_out_oe_n(oe_n), .o_thresh_sel(thr_q),
    .o_mode(mode), .o_wdog_cfg(cfg), .o_status(st));
  rws_host_model u_host (.i_ref_clk(i_ref_clk), .o_chip_select_n(cs_n),
    .o_wdog_wr(wd_wr), .o_wdog_wdata(wd_data));

  // ********************
  // helpers
  // ********************
  // clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // bounded wait; tick phase makes the edge drift by up to a tick
  task automatic wait_oe(input logic v, input int n);
    for (int k = 0; k < n && oe_n !== v; k++) cyc(1);
    chk(8'(oe_n), 8'(v));
  endtask
  task automatic set_mode(input logic [1:0] c);
    mode_cmd = c;
    mode_wr = 1'b1;
    cyc(1);
    mode_wr = 1'b0;
    cyc(1);
  endtask
  task automatic clr();
    st_clr = 1'b1;
    cyc(1);
    st_clr = 1'b0;
  endtask
  function automatic logic [6:0] wdb(input logic win, input logic [2:0] per);
    return {2'b00, win, 1'b0, per};
  endfunction
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_power_up();
    cyc(20);
    chk(8'(oe_n), 8'h00);
    chk(8'(rst_n), 8'h00);
    chk(8'(mode), 8'(rws_pkg::RWS_INIT));
    chk(8'(cfg), 8'h05);
    chk(8'(thr_q), 8'h00);
    uv = 1'b0;
    cyc(900);
    chk(8'(oe_n), 8'h00);
    wait_oe(1'b1, 200);
    set_mode(2'h0);
    thr_sel = 2'h2;
    thr_wr = 1'b1;
    cyc(1);
    thr_wr = 1'b0;
    chk(8'(thr_q), 8'h02);
  endtask
  // unserved long window ends in a reset; pin held high meanwhile
  task automatic t_wdog_failure_flags();
    clr();
    cyc(25);
    chk(8'(oe_n), 8'h01);
    wait_oe(1'b0, 60);
    cyc(2);
    chk(8'(mode), 8'(rws_pkg::RWS_RESTART));
    chk(8'(st.wdog_failure_flag), 8'h01);
    clamp_hi = 1'b1;
    cyc(4);
    clamp_hi = 1'b0;
    chk(8'(st.reset_clamp_flag), 8'h01);
    wait_oe(1'b1, 1200);
    cyc(2);
    chk(8'(mode), 8'(rws_pkg::RWS_NORMAL));
  endtask
  task automatic t_timeout();
    for (int p = 7; p > 0; p--) begin
      u_host.send(wdb(1'b0, 3'(p)), 1'b0);
      chk(8'(cfg), 8'(p));
    end
    cyc(940);
    chk(8'(oe_n), 8'h01);
    wait_oe(1'b0, 120);
    wait_oe(1'b1, 1200);
    cyc(2);
  endtask
  // early trigger fails; trigger in the open part is kept
  task automatic t_window();
    u_host.send(wdb(1'b1, 3'h1), 1'b0);
    chk(8'(cfg), 8'h11);
    cyc(300);
    u_host.send(wdb(1'b1, 3'h1), 1'b0);
    wait_oe(1'b0, 20);
    wait_oe(1'b1, 1200);
    cyc(2);
    u_host.send(wdb(1'b1, 3'h1), 1'b0);
    cyc(750);
    u_host.send(wdb(1'b1, 3'h1), 1'b0);
    cyc(100);
    chk(8'(oe_n), 8'h01);
  endtask
  task automatic t_soft();
    cyc(650);
    u_host.send(wdb(1'b0, 3'h1), 1'b0);
    u_host.send(wdb(1'b0, 3'h2), 1'b1);
    chk(8'(st.serial_fail_flag), 8'h01);
    chk(8'(cfg), 8'h01);
    set_mode(2'h2);
    chk(8'(mode), 8'(rws_pkg::RWS_STOP));
    u_host.send(wdb(1'b0, 3'h3), 1'b0);
    chk(8'(cfg), 8'h01);
    set_mode(2'h3);
    chk(8'(oe_n), 8'h01);
    chk(8'(mode), 8'(rws_pkg::RWS_INIT));
    chk(8'(cfg), 8'h05);
    chk(8'(thr_q), 8'h00);
  endtask
  // clamp must stay unjudged while the supply is low
  task automatic t_uv();
    set_mode(2'h0);
    u_host.send(wdb(1'b0, 3'h5), 1'b0);
    clr();
    uv = 1'b1;
    clamp_hi = 1'b1;
    wait_oe(1'b0, 30);
    ge_1v = 1'b0;
    cyc(1);
    chk(8'(oe_n), 8'h01);
    ge_1v = 1'b1;
    cyc(3);
    chk(8'(st.reset_clamp_flag), 8'h00);
    chk(8'(st.core_supply_undervolt_flag), 8'h01);
    clamp_hi = 1'b0;
    cyc(50);
    chk(8'(oe_n), 8'h00);
    uv = 1'b0;
    cyc(900);
    chk(8'(oe_n), 8'h00);
    wait_oe(1'b1, 200);
  endtask
  task automatic t_sleep();
    cyc(2);
    set_mode(2'h0);
    set_mode(2'h1);
    chk(8'(mode), 8'(rws_pkg::RWS_SLEEP));
    set_mode(2'h3);
    chk(8'(mode), 8'(rws_pkg::RWS_SLEEP));
    cyc(100);
    chk(8'(oe_n), 8'h01);
    // stop-off set in Normal: Stop then runs past a full period unserved
    set_mode(2'h0);
    u_host.send(7'h09, 1'b0);
    chk(8'(cfg), 8'h09);
    set_mode(2'h2);
    cyc(1100);
    chk(8'(mode), 8'(rws_pkg::RWS_STOP));
    chk(8'(oe_n), 8'h01);
  endtask

  // main sequence; battery stays good throughout
  initial begin
    i_reset = 1'b1;
    uv = 1'b1;
    ge_1v = 1'b1;
    bat_ok = 1'b1;
    clamp_hi = 1'b0;
    thr_sel = 2'h0;
    thr_wr = 1'b0;
    mode_cmd = 2'h0;
    mode_wr = 1'b0;
    st_clr = 1'b0;
    cyc(3);
    i_reset = 1'b0;
    t_power_up();
    t_wdog_failure_flags();
    t_timeout();
    t_window();
    t_soft();
    t_uv();
    t_sleep();
    summarize();
  end
  // hang guard, about three times the expected run
  initial begin
    #300000;
    error_cnt++;
    summarize();
  end
endmodule
